/* rtl/key_matrix_scanner.sv */
// Purpose: Key matrix scanner sharing segment pins with key drive
// Assumes: Register requests are single-cycle strobes on core_clk
// Notes: Segment waveform arrives from the display controller as seg_data
// Behaviour
// - Drive sixteen scan lines and sense four return inputs, up to 64 keys.
// - Scan pins alternate in time between segment output and key drive.
// - Scan pattern register at 42H, bit n drives scan line n.
// - In a drive slot, pattern bit 1 drives high, bit 0 drives low.
// - Segment waveforms appear only while segment drive is on.
// - Segment drive off forces all shared pins low and stops drive slots.
// - Drive slots happen only with segment drive and scan output both on.
// - Drive slot lasts 220 us and recurs every 4 ms.
// - Segment pins above line 15 output low during the drive slot.
// - Return pull-downs are on only during the drive slot.
// - Return inputs reach the latch only during the drive slot.
// - Latched return value is read at address 73H.
// - Return sampling follows slot timing; return pins are key inputs then.
// - Completion flag at 16H sets after a full 220 us slot.
// - Completion flag clears on pattern write and on its own read.
`timescale 1ns/10ps
`default_nettype none
module key_matrix_scanner
  import key_scan_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES,
  parameter int unsigned SLOT_LEN = SLOT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire reg_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  input wire logic [29:0] seg_data,
  input wire logic [3:0] key_return,
  output seg_pins_t pins,
  output logic [3:0] pulldown_on,
  output logic key_input_mode
);

  logic [15:0] scan_pattern_q;
  logic segment_drive_on_q;
  logic scan_output_on_q;
  logic scan_done_flag_q;
  logic [3:0] key_return_q;
  logic in_slot;
  logic slot_end;
  logic run;
  logic wr_pattern;
  logic rd_judge;

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  assign run = segment_drive_on_q && scan_output_on_q;
  assign wr_pattern = req.wr && hit(req, SCAN_PATTERN_ADDR);
  assign rd_judge = req.rd && hit(req, KEY_JUDGE_ADDR);

  slot_timer #(
    .FRAME_LEN(FRAME_LEN),
    .SLOT_LEN(SLOT_LEN)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(run),
    .in_slot(in_slot),
    .slot_end(slot_end)
  );

  return_latch u_latch (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sample(in_slot),
    .key_in(key_return),
    .key_q(key_return_q)
  );

  // Pattern register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_pattern_q <= SCAN_PATTERN_RESET;
    end else if (wr_pattern) begin
      scan_pattern_q <= req.wdata;
    end
  end

  // Mode flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      segment_drive_on_q <= 1'b0;
      scan_output_on_q <= 1'b0;
    end else if (req.wr && hit(req, MODE_SELECT_ADDR)) begin
      segment_drive_on_q <= req.wdata[SEG_ON_BIT];
      scan_output_on_q <= req.wdata[SCAN_ON_BIT];
    end
  end

  // Completion flag, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_done_flag_q <= 1'b0;
    end else if (slot_end) begin
      scan_done_flag_q <= 1'b1;
    end else if (wr_pattern || rd_judge) begin
      scan_done_flag_q <= 1'b0;
    end
  end

  // Read port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rdata <= 16'h0000;
      if (req.rd) begin
        unique case (req.addr)
          KEY_JUDGE_ADDR: rdata <= {15'h0000, scan_done_flag_q};
          KEY_RETURN_ADDR: rdata <= {12'h000, key_return_q};
          MODE_SELECT_ADDR: rdata <= {14'h0000, scan_output_on_q, segment_drive_on_q};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Shared pin multiplexing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.level <= 30'h0000_0000;
      pins.oe <= 30'h3FFF_FFFF;
    end else begin
      pins.oe <= 30'h3FFF_FFFF;
      if (!segment_drive_on_q) begin
        pins.level <= 30'h0000_0000;
      end else if (in_slot) begin
        pins.level <= {14'h0000, scan_pattern_q};
      end else begin
        pins.level <= seg_data;
      end
    end
  end

  // Return pin control
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulldown_on <= 4'h0;
      key_input_mode <= 1'b0;
    end else begin
      pulldown_on <= {4{in_slot}};
      key_input_mode <= run;
    end
  end

endmodule
`default_nettype wire

/* common/key_scan_pkg.sv */
// Purpose: Shared constants and types for the key matrix scanner
// Assumes: 40 MHz core clock
// Notes: Register offsets are the device's own register addresses
package key_scan_pkg;

  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SLOT_US = 220;
  localparam int unsigned FRAME_MS = 4;
  localparam int unsigned SLOT_CYCLES = (SLOT_US * (CLK_HZ / 1000000));
  localparam int unsigned FRAME_CYCLES = (FRAME_MS * (CLK_HZ / 1000));

  localparam int unsigned SCAN_LINES = 16;
  localparam int unsigned SEG_PINS = 30;
  localparam int unsigned RET_LINES = 4;

  localparam logic [7:0] KEY_JUDGE_ADDR = 8'h16;
  localparam logic [7:0] SCAN_PATTERN_ADDR = 8'h42;
  localparam logic [7:0] KEY_RETURN_ADDR = 8'h73;
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h50;

  localparam int unsigned DONE_BIT = 0;
  localparam int unsigned SEG_ON_BIT = 0;
  localparam int unsigned SCAN_ON_BIT = 1;

  localparam logic [15:0] SCAN_PATTERN_RESET = 16'h0000;
  localparam logic [3:0] KEY_RETURN_RESET = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [29:0] level;
    logic [29:0] oe;
  } seg_pins_t;

endpackage

/* rtl/slot_timer.sv */
// Purpose: Frame timer marking the key drive slot inside each frame
// Assumes: Counts run on core_clk
// Notes: Slot occupies the first part of each frame
`timescale 1ns/10ps
`default_nettype none
module slot_timer
  import key_scan_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES,
  parameter int unsigned SLOT_LEN = SLOT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  output logic in_slot,
  output logic slot_end
);

  logic [31:0] count_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 32'h0000_0000;
    end else if (!run || count_q == 32'(FRAME_LEN - 1)) begin
      count_q <= 32'h0000_0000;
    end else begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  assign in_slot = run && (count_q < 32'(SLOT_LEN));
  assign slot_end = run && (count_q == 32'(SLOT_LEN - 1));

endmodule
`default_nettype wire

/* rtl/return_latch.sv */
// Purpose: Capture of the four key return inputs during the drive slot
// Assumes: Return inputs synchronous to core_clk
// Notes: Value holds between slots
`timescale 1ns/10ps
`default_nettype none
module return_latch
  import key_scan_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sample,
  input wire logic [3:0] key_in,
  output logic [3:0] key_q
);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_q <= KEY_RETURN_RESET;
    end else if (sample) begin
      key_q <= key_in;
    end
  end

endmodule
`default_nettype wire

/* verification/key_scan_monitor.sv */
// Purpose: Port assertions for the key scanner
// Assumes: One clock domain
// Notes: Bound to each scanner
`timescale 1ns/10ps
`default_nettype none
module key_scan_monitor
  import key_scan_pkg::*;
#(
  parameter int unsigned SLOT_LEN = SLOT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire reg_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic [29:0] seg_data,
  input wire seg_pins_t pins,
  input wire logic [3:0] pulldown_on,
  input wire logic key_input_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] on_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) on_q <= 32'h0;
    else on_q <= pulldown_on[0] ? on_q + 32'h1 : 32'h0;
  end
  a_pd_equal: assert property (pulldown_on == 4'h0 || pulldown_on == 4'hF)
    else $error("pulldowns differ");
  a_upper_low: assert property (pulldown_on[0] |-> pins.level[29:16] == 14'h0)
    else $error("upper pin high");
  a_seg_pass: assert property (key_input_mode && $past(key_input_mode, 2)
    && !pulldown_on[0] |-> pins.level == $past(seg_data)) else $error("segment lost");
  a_slot_mode: assert property (pulldown_on[0] |-> key_input_mode)
    else $error("slot without mode");
  a_read_ans: assert property (req.rd |=> rvalid) else $error("no answer");
  a_read_only: assert property (rvalid |-> $past(req.rd)) else $error("stray answer");
  a_rdata_idle: assert property (!rvalid |-> rdata == 16'h0) else $error("idle data");
  a_slot_len: assert property ($fell(pulldown_on[0]) |-> on_q == SLOT_LEN)
    else $error("slot length");
endmodule
bind key_matrix_scanner key_scan_monitor #(.SLOT_LEN(SLOT_LEN)) mon_u (.*);
`default_nettype wire

/* verification/key_matrix_model.sv */
// Purpose: Passive key matrix with diodes
// Assumes: closed bit r*16+n joins line n to return r
// Notes: A return without pull-down reads inverted
`timescale 1ns/10ps
`default_nettype none
module key_matrix_model
  import key_scan_pkg::*;
(
  input wire seg_pins_t pins,
  input wire logic [3:0] pulldown_on,
  input wire logic [63:0] closed,
  output logic [3:0] key_return
);
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      key_return[r] = |(pins.level[15:0] & closed[r*16+:16]) ^ !pulldown_on[r];
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for the key scanner
// Assumes: Frame of 40 and slot of 8 cycles
// Notes: Inputs move on the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb;
  import key_scan_pkg::*;
  localparam logic [7:0] ADR [4] = '{KEY_JUDGE_ADDR, SCAN_PATTERN_ADDR, KEY_RETURN_ADDR, 8'hFF};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t req = '0;
  logic [29:0] seg_data = 30'h2AAAAAAA;
  logic [63:0] closed = 64'h8000000000800001;
  logic [15:0] rdata, v;
  logic [3:0] key_return, pulldown_on;
  logic rvalid, key_input_mode;
  seg_pins_t pins;
  int fails = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  key_matrix_scanner #(.FRAME_LEN(40), .SLOT_LEN(8)) dut_u (.*);
  key_matrix_model far_u (.*);
  task automatic end_sim();
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req = '{w, !w, a, d};
    @(negedge core_clk);
    req = '0;
    v = rdata;
    if (!w) `CHK(rvalid, 1'b1)
  endtask
  task automatic reset_vals();
    acc(1'b1, KEY_RETURN_ADDR, 16'hFFFF);
    foreach (ADR[k]) begin
      acc(1'b0, ADR[k], 16'h0000);
      `CHK(v, 16'h0000)
    end
  endtask
  task automatic scan();
    int i;
    acc(1'b1, SCAN_PATTERN_ADDR, 16'h8001);
    acc(1'b1, MODE_SELECT_ADDR, 16'h0003);
    for (i = 0; i < 60 && pulldown_on[0] !== 1'b1; i++) @(negedge core_clk);
    `CHK({pulldown_on, pins.level}, {4'hF, 14'h0000, 16'h8001})
    for (i = 0; i < 40 && v[0] !== 1'b1; i++) acc(1'b0, KEY_JUDGE_ADDR, 16'h0000);
    `CHK(v[0], 1'b1)
    acc(1'b0, KEY_RETURN_ADDR, 16'h0000);
    `CHK(v[3:0], 4'h9)
    acc(1'b0, KEY_JUDGE_ADDR, 16'h0000);
    `CHK(v[0], 1'b0)
    // Let the next slot set the flag unread, then clear it by a pattern write
    for (i = 0; i < 60 && pulldown_on[0] !== 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < 20 && pulldown_on[0] !== 1'b0; i++) @(negedge core_clk);
    acc(1'b1, SCAN_PATTERN_ADDR, 16'h8001);
    acc(1'b0, KEY_JUDGE_ADDR, 16'h0000);
    `CHK(v[0], 1'b0)
  endtask
  task automatic modes();
    int n;
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, MODE_SELECT_ADDR, 16'(m));
      n = 0;
      for (int i = 0; i < 90; i++) begin
        @(negedge core_clk);
        n += int'(pulldown_on[0] === 1'b1);
        if (i > 2 && m != 3) `CHK(pins.level, m == 1 ? seg_data : 30'h0)
      end
      `CHK({n > 0, key_input_mode}, {2{m == 3}})
    end
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    reset_vals();
    scan();
    modes();
    end_sim();
  end
endmodule
`default_nettype wire
